// *** design/cpu_seq_regs.svh ***
`ifndef CPU_SEQ_REGS_SVH
`define CPU_SEQ_REGS_SVH

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define PC_WIDTH 10
`define STACK_DEPTH 4
`define INSTR_WIDTH 15
`define RESET_VECTOR 12'h000
`define IRQ_VECTOR 12'h004
`define NOP_WORD 15'h0000

// ----------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------
`define F_CLASS_HI 14
`define F_CLASS_LO 12
`define F_SUB_HI 11
`define F_SUB_LO 8
`define F_OPND_HI 7

// ----------------------------------------------------------------
// special data addresses
// ----------------------------------------------------------------
`define PC_LOW_BYTE_ADDR 8'h06
`define TBL_LOW_ADDR 8'h07
`define TBL_HIGH_ADDR 8'h08
`define STATUS_ADDR 8'h0A

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define ST_C 0
`define ST_AC 1
`define ST_Z 2
`define ST_OV 3

`endif

// *** design/cpu_seq_pkg.sv ***
package cpu_seq_pkg;
    typedef enum logic [3:0] {
        PH_T1 = 4'h1, PH_T2 = 4'h2, PH_T3 = 4'h4, PH_T4 = 4'h8
    } phase_type;
    typedef enum logic [2:0] {
        CL_MISC = 3'h0, CL_ALU_ACC = 3'h1, CL_ALU_MEM = 3'h2, CL_ALU_IMM = 3'h3,
        CL_SKIP = 3'h4, CL_STORE = 3'h5, CL_JUMP = 3'h6, CL_CALL = 3'h7
    } op_class_type;
    typedef enum logic [3:0] {
        AL_ADD = 4'h0, AL_ADC = 4'h1, AL_SUB = 4'h2, AL_SBC = 4'h3,
        AL_DAA = 4'h4, AL_AND = 4'h5, AL_OR = 4'h6, AL_XOR = 4'h7,
        AL_CPL = 4'h8, AL_RR = 4'h9, AL_RRC = 4'hA, AL_RL = 4'hB,
        AL_RLC = 4'hC, AL_INC = 4'hD, AL_DEC = 4'hE, AL_PASS = 4'hF
    } alu_op_type;
    typedef enum logic [3:0] {
        MI_NOP = 4'h0, MI_RETURN = 4'h1, MI_RETURN_INT = 4'h2, MI_INT_ENABLE = 4'h3
    } misc_type;
    typedef enum logic [3:0] {
        SK_ZERO = 4'h0, SK_NONZERO = 4'h1, SK_INC_ZERO = 4'h2, SK_DEC_ZERO = 4'h3
    } skip_type;
endpackage : cpu_seq_pkg

// *** design/cpu_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cpu_seq_regs.svh"
module cpu_alu (
    input wire cpu_seq_pkg::alu_op_type op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic c_in,
    input wire logic ac_in,
    output logic [7:0] y,
    output logic [3:0] flags,
    output logic [3:0] upd
);
    import cpu_seq_pkg::*;

    function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] w,
                                        input logic ci);
        add9 = {1'b0, x} + {1'b0, w} + {8'h00, ci};
    endfunction : add9

    logic [7:0] bx;
    logic cin;
    logic [8:0] s;
    logic [4:0] lo;
    logic [8:0] adj;

    // subtract is add of the complement; carry set means no borrow
    always_comb begin
        bx = (op == AL_SUB || op == AL_SBC) ? ~b : b;
        cin = (op == AL_ADC || op == AL_SBC) ? c_in : (op == AL_SUB);
        s = add9(a, bx, cin);
        lo = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
        adj = add9(a, (a[3:0] > 4'h9 || ac_in) ? 8'h06 : 8'h00, 1'b0);
        y = s[7:0];
        flags = 4'h0;
        upd = 4'h0;
        flags[`ST_C] = c_in;
        case (op)
            AL_ADD, AL_ADC, AL_SUB, AL_SBC: begin
                flags[`ST_C] = s[8];
                flags[`ST_AC] = lo[4];
                flags[`ST_OV] = (a[7] == bx[7]) && (s[7] != a[7]);
                upd = 4'hF;
            end
            AL_DAA: begin
                y = adj[7:0];
                if (adj[8] || c_in || adj[7:0] > 8'h99) begin
                    y = adj[7:0] + 8'h60;
                    flags[`ST_C] = 1'b1;
                end
                upd[`ST_C] = 1'b1;
            end
            AL_AND: begin y = a & b; upd[`ST_Z] = 1'b1; end
            AL_OR: begin y = a | b; upd[`ST_Z] = 1'b1; end
            AL_XOR: begin y = a ^ b; upd[`ST_Z] = 1'b1; end
            AL_CPL: begin y = ~b; upd[`ST_Z] = 1'b1; end
            AL_RR: y = {b[0], b[7:1]};
            AL_RRC: begin y = {c_in, b[7:1]}; flags[`ST_C] = b[0]; upd[`ST_C] = 1'b1; end
            AL_RL: y = {b[6:0], b[7]};
            AL_RLC: begin y = {b[6:0], c_in}; flags[`ST_C] = b[7]; upd[`ST_C] = 1'b1; end
            AL_INC: begin y = b + 8'h01; upd[`ST_Z] = 1'b1; end
            AL_DEC: begin y = b - 8'h01; upd[`ST_Z] = 1'b1; end
            AL_PASS: y = b;
            default: y = b;
        endcase
        flags[`ST_Z] = (y == 8'h00);
    end
endmodule : cpu_alu
`default_nettype wire

// *** design/cpu_return_stack.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cpu_seq_regs.svh"
module cpu_return_stack #(
    parameter int DEPTH = `STACK_DEPTH,
    parameter int W = `PC_WIDTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic push,
    input wire logic pop,
    input wire logic [W-1:0] push_data,
    output logic [W-1:0] top,
    output logic full
);
    import cpu_seq_pkg::*;
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] ptr;
        logic [PW:0] count;
    } stack_type;
    stack_type s_q, s_d;

    // circular store: a push when full lands on the oldest entry and loses it
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.ptr] = push_data;
            s_d.ptr = s_q.ptr + 1'b1;
            if (s_q.count != DEPTH[PW:0]) s_d.count = s_q.count + 1'b1;
        end else if (pop) begin
            s_d.ptr = s_q.ptr - 1'b1;
            if (s_q.count != '0) s_d.count = s_q.count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) s_q <= '0;
        else s_q <= s_d;
    end

    assign top = s_q.mem[s_q.ptr - 1'b1];
    assign full = (s_q.count == DEPTH[PW:0]);

    chk_depth_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.count <= DEPTH[PW:0]) else $error("stack count beyond depth");
    chk_overflow_push: assert property (@(posedge ref_clk) disable iff (!resetn)
        (push && full) |=> full && top == $past(push_data))
        else $error("push on full stack did not proceed");
endmodule : cpu_return_stack
`default_nettype wire

// *** design/cpu_fetch_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cpu_seq_regs.svh"
// How it works
// - four one-hot phases make one instruction cycle
// - program counter advances entering phase one
// - fetch overlaps execute; redirects cost a cycle
// - jump or call takes two instruction cycles
// - counter steps by one unless control transfers
// - only low counter byte is software visible
// - low byte write jumps within current page
// - low byte write inserts one dummy cycle
// - taken skip discards fetched word, dummy cycle
// - jumps, calls, interrupts, reset load target address
// - return stack holds counter values, software-invisible
// - call or interrupt acknowledge pushes counter
// - returns restore counter from stack
// - reset points stack at its top
// - full stack withholds interrupt acknowledge, flag kept
// - call on full stack overflows, oldest lost
// - stack depth is a per-variant parameter
// - eight-bit ALU, data through the accumulator
// - add, subtract, logic, rotate, inc, dec, skip
// - ALU results update the status flags
// - counter addresses program memory of variant size
// - separate table pointer addresses program memory
// - execution starts at location zero after reset
module cpu_fetch_seq #(
    parameter int PC_W = `PC_WIDTH,
    parameter int STACK_DEPTH = `STACK_DEPTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    output logic [PC_W-1:0] pmem_addr,
    input wire logic [`INSTR_WIDTH-1:0] pmem_data,
    output logic [PC_W-1:0] tbl_ptr,
    output logic [7:0] dmem_addr,
    input wire logic [7:0] dmem_rdata,
    output logic [7:0] dmem_wdata,
    output logic dmem_we,
    input wire logic irq_req,
    output logic irq_ack,
    output cpu_seq_pkg::phase_type phase,
    output logic [7:0] acc,
    output logic [3:0] status
);
    import cpu_seq_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        phase_type phase;
        logic [PC_W-1:0] pc;
        logic [`INSTR_WIDTH-1:0] ir;
        logic flush;
        logic [7:0] acc;
        logic [3:0] status;
        logic [PC_W-1:0] tbl;
        logic gie;
        logic irq_flag;
        logic irq_s1;
        logic irq_s2;
        logic irq_s3;
        logic we;
        logic [7:0] wdata;
        logic ack;
    } state_type;
    state_type s_q, s_d;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    op_class_type cls;
    logic [3:0] sub;
    logic [7:0] opnd;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] pc_inc;
    logic [7:0] mem_val;
    alu_op_type alu_op;
    logic [7:0] alu_b;
    logic [7:0] alu_y;
    logic [3:0] alu_flags;
    logic [3:0] alu_upd;
    logic [7:0] wval;
    logic exec;
    logic wr_mem;
    logic is_jump;
    logic is_call;
    logic is_ret;
    logic is_return_from_interrupt;
    logic pcl_write;
    logic skip_taken;
    logic redirect;
    logic irq_take;
    logic stack_push;
    logic stack_pop;
    logic [PC_W-1:0] stack_top;
    logic stack_full;

    assign cls = op_class_type'(s_q.ir[`F_CLASS_HI:`F_CLASS_LO]);
    assign sub = s_q.ir[`F_SUB_HI:`F_SUB_LO];
    assign opnd = s_q.ir[`F_OPND_HI:0];
    assign target = s_q.ir[PC_W-1:0];
    assign pc_inc = s_q.pc + {{(PC_W-1){1'b0}}, 1'b1};
    // the dummy cycle carries the discarded word; it must do nothing
    assign exec = !s_q.flush;

    // low counter byte, status and table pointer sit in data space;
    // the stack and its pointer never do
    always_comb begin
        case (opnd)
            `PC_LOW_BYTE_ADDR: mem_val = s_q.pc[7:0];
            `STATUS_ADDR: mem_val = {4'h0, s_q.status};
            `TBL_LOW_ADDR: mem_val = s_q.tbl[7:0];
            `TBL_HIGH_ADDR: mem_val = 8'(s_q.tbl[PC_W-1:8]);
            default: mem_val = dmem_rdata;
        endcase
    end

    always_comb begin
        alu_op = alu_op_type'(sub);
        if (cls == CL_SKIP) begin
            case (sub)
                SK_INC_ZERO: alu_op = AL_INC;
                SK_DEC_ZERO: alu_op = AL_DEC;
                default: alu_op = AL_PASS;
            endcase
        end
    end

    assign alu_b = (cls == CL_ALU_IMM) ? opnd : mem_val;

    cpu_alu u_alu (
        .op(alu_op),
        .a(s_q.acc),
        .b(alu_b),
        .c_in(s_q.status[`ST_C]),
        .ac_in(s_q.status[`ST_AC]),
        .y(alu_y),
        .flags(alu_flags),
        .upd(alu_upd)
    );

    assign wval = (cls == CL_STORE) ? s_q.acc : alu_y;
    assign wr_mem = exec && (cls == CL_ALU_MEM || cls == CL_STORE ||
        (cls == CL_SKIP && (sub == SK_INC_ZERO || sub == SK_DEC_ZERO)));
    assign is_jump = exec && cls == CL_JUMP;
    assign is_call = exec && cls == CL_CALL;
    assign is_ret = exec && cls == CL_MISC && sub == MI_RETURN;
    assign is_return_from_interrupt = exec && cls == CL_MISC && sub == MI_RETURN_INT;
    assign pcl_write = wr_mem && opnd == `PC_LOW_BYTE_ADDR;
    assign skip_taken = exec && cls == CL_SKIP &&
        ((sub == SK_NONZERO) ? alu_y != 8'h00 : alu_y == 8'h00);
    assign redirect = is_jump || is_call || is_ret || is_return_from_interrupt || pcl_write || skip_taken;

    // interrupt only between ordinary instructions, never on a full stack
    assign irq_take = s_q.phase == PH_T4 && s_q.irq_flag && s_q.gie &&
        !stack_full && !redirect;
    assign stack_push = s_q.phase == PH_T4 && (is_call || irq_take);
    assign stack_pop = s_q.phase == PH_T4 && (is_ret || is_return_from_interrupt);

    cpu_return_stack #(
        .DEPTH(STACK_DEPTH),
        .W(PC_W)
    ) u_stack (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .push(stack_push),
        .pop(stack_pop),
        .push_data(s_q.pc),
        .top(stack_top),
        .full(stack_full)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.irq_s1 = irq_req;
        s_d.irq_s2 = s_q.irq_s1;
        s_d.irq_s3 = s_q.irq_s2;
        // a new request beats the acknowledge that clears the flag
        s_d.irq_flag = (s_q.irq_s2 && !s_q.irq_s3) || (s_q.irq_flag && !irq_take);
        case (s_q.phase)
            PH_T1: s_d.phase = PH_T2;
            PH_T2: s_d.phase = PH_T3;
            PH_T3: begin
                s_d.phase = PH_T4;
                s_d.we = wr_mem && opnd != `PC_LOW_BYTE_ADDR && opnd != `STATUS_ADDR &&
                    opnd != `TBL_LOW_ADDR && opnd != `TBL_HIGH_ADDR;
                s_d.wdata = wval;
            end
            PH_T4: begin
                s_d.phase = PH_T1;
                s_d.we = 1'b0;
                s_d.ir = pmem_data;
                s_d.flush = redirect || irq_take;
                s_d.pc = pc_inc;
                if (exec) begin
                    if (cls == CL_ALU_ACC || cls == CL_ALU_IMM) s_d.acc = alu_y;
                    if (cls == CL_ALU_ACC || cls == CL_ALU_IMM || cls == CL_ALU_MEM ||
                        cls == CL_SKIP) begin
                        s_d.status = (s_q.status & ~alu_upd) | (alu_flags & alu_upd);
                    end
                    if (cls == CL_MISC && sub == MI_INT_ENABLE) s_d.gie = 1'b1;
                end
                if (wr_mem) begin
                    case (opnd)
                        `STATUS_ADDR: s_d.status = wval[3:0];
                        `TBL_LOW_ADDR: s_d.tbl[7:0] = wval;
                        `TBL_HIGH_ADDR: s_d.tbl[PC_W-1:8] = wval[PC_W-9:0];
                        default: s_d.tbl = s_q.tbl;
                    endcase
                end
                if (is_jump || is_call) s_d.pc = target;
                if (is_ret || is_return_from_interrupt) s_d.pc = stack_top;
                if (is_return_from_interrupt) s_d.gie = 1'b1;
                if (pcl_write) s_d.pc = {s_q.pc[PC_W-1:8], wval};
                if (irq_take) begin
                    s_d.pc = PC_W'(`IRQ_VECTOR);
                    s_d.gie = 1'b0;
                    s_d.ack = 1'b1;
                end
            end
            default: s_d.phase = PH_T1;
        endcase
    end

    // the first cycle after reset is a dummy while location zero is fetched
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{phase: PH_T1, pc: PC_W'(`RESET_VECTOR), ir: `NOP_WORD,
                     flush: 1'b1, acc: 8'h00, status: 4'h0, tbl: '0, gie: 1'b0,
                     irq_flag: 1'b0, irq_s1: 1'b0, irq_s2: 1'b0, irq_s3: 1'b0,
                     we: 1'b0, wdata: 8'h00, ack: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pmem_addr = s_q.pc;
    assign tbl_ptr = s_q.tbl;
    assign dmem_addr = opnd;
    assign dmem_wdata = s_q.wdata;
    assign dmem_we = s_q.we;
    assign irq_ack = s_q.ack;
    assign phase = s_q.phase;
    assign acc = s_q.acc;
    assign status = s_q.status;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence seq_four_phases;
        s_q.phase == PH_T1 ##1 s_q.phase == PH_T2 ##1 s_q.phase == PH_T3 ##1
        s_q.phase == PH_T4;
    endsequence

    sequence seq_dummy_cycle;
        s_q.flush [*4];
    endsequence

    chk_phase_cycle: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.phase == PH_T1 |-> seq_four_phases ##1 s_q.phase == PH_T1)
        else $error("phase sequence broken");
    chk_pc_at_t1: assert property (@(posedge ref_clk) disable iff (!resetn)
        !$stable(s_q.pc) |-> s_q.phase == PH_T1 && $past(s_q.phase) == PH_T4)
        else $error("counter moved outside the start of phase one");
    chk_pc_step: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T4 && !redirect && !irq_take) |=> s_q.pc == $past(pc_inc))
        else $error("counter did not step by one");
    chk_redirect_dummy: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T4 && (is_jump || is_call)) |=>
        seq_dummy_cycle ##1 (!s_q.flush || s_q.ack))
        else $error("branch without exactly one dummy cycle");
    chk_pcl_page: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T4 && pcl_write) |=> s_q.flush &&
        s_q.pc == {$past(s_q.pc[PC_W-1:8]), $past(wval)})
        else $error("low byte jump left the page");
    chk_skip_dummy: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T4 && skip_taken) |=> seq_dummy_cycle)
        else $error("taken skip executed the fetched word");
    chk_irq_withheld: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T4 && stack_full) |=> !s_q.ack)
        else $error("interrupt acknowledged on a full stack");
    chk_irq_flag_kept: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.irq_flag && !irq_take) |=> s_q.irq_flag)
        else $error("pending interrupt flag lost");
    chk_return_pc: assert property (@(posedge ref_clk) disable iff (!resetn)
        stack_pop |=> s_q.pc == $past(stack_top) ##1 s_q.flush)
        else $error("return did not restore the counter");
    chk_irq_vector: assert property (@(posedge ref_clk) disable iff (!resetn)
        irq_take |-> stack_push ##1 (s_q.ack && s_q.pc == PC_W'(`IRQ_VECTOR)))
        else $error("interrupt entry wrong");
    chk_write_strobe: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.we |-> s_q.phase == PH_T4 ##1 !s_q.we)
        else $error("data write strobe outside phase four");
    chk_status_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T4 && exec && cls == CL_ALU_IMM && alu_upd[`ST_Z]) |=>
        s_q.status[`ST_Z] == (s_q.acc == 8'h00))
        else $error("zero flag disagrees with result");
    chk_pcl_internal: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T3 && pcl_write) |=> !s_q.we)
        else $error("low byte write reached the data bus");
    chk_dummy_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T3 && s_q.flush) |=> !s_q.we)
        else $error("dummy cycle wrote data");
    chk_flush_source: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T4 && !redirect && !irq_take) |=> !s_q.flush)
        else $error("dummy cycle without a redirect");
    chk_fetch_edge: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.phase != PH_T4 |=> $stable(s_q.ir))
        else $error("instruction word changed outside phase four");
    chk_acc_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.phase != PH_T4 |=> $stable(s_q.acc))
        else $error("accumulator changed outside phase four");
    chk_phase_onehot: assert property (@(posedge ref_clk) disable iff (!resetn)
        $onehot(s_q.phase))
        else $error("phase not one-hot");

    // ------------------------------------------------------------
    // stack and interrupt checks
    // ------------------------------------------------------------
    chk_call_push: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T4 && is_call) |-> stack_push ##1 stack_top == $past(s_q.pc))
        else $error("call did not save the return address");
    chk_ack_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.ack |=> !s_q.ack)
        else $error("acknowledge longer than one clock");
    chk_irq_masks: assert property (@(posedge ref_clk) disable iff (!resetn)
        irq_take |=> !s_q.gie)
        else $error("interrupt entry left interrupts enabled");
    // a return frees a level, so a pending request is taken when its dummy ends
    chk_ret_service: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.phase == PH_T4 && stack_pop && s_q.irq_flag && s_q.gie) |-> ##4 irq_take)
        else $error("pending interrupt not served after return");
endmodule : cpu_fetch_seq
`default_nettype wire

// *** verif/cpu_pmem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cpu_seq_regs.svh"
module cpu_pmem_model #(
    parameter int PC_W = 10
) (
    input wire logic [PC_W-1:0] addr,
    output logic [`INSTR_WIDTH-1:0] data
);
    // ----------
    // flash array
    // ----------
    logic [`INSTR_WIDTH-1:0] mem [0:(1<<PC_W)-1];

    // read without wait states; empty words decode as no-operation
    assign data = mem[addr];

    initial begin
        foreach (mem[i]) mem[i] = `NOP_WORD;
    end
endmodule : cpu_pmem_model
`default_nettype wire

// *** verif/cpu_fetch_pc_stack_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cpu_seq_regs.svh"
module cpu_fetch_pc_stack_control_bench;
    import cpu_seq_pkg::*;
    localparam int PW = 10;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic irq_req = 1'b0;
    logic [PW-1:0] pmem_addr, pa_q, prv, tbl_ptr;
    logic [`INSTR_WIDTH-1:0] pmem_data;
    logic [7:0] dmem_addr, dmem_rdata, dmem_wdata, acc;
    logic dmem_we, irq_ack;
    logic [3:0] status, ph_q;
    phase_type phase;
    logic [7:0] wr [0:255];
    logic [3:0] ws [0:255];
    logic [7:0] va [0:10], vb [0:10];
    int miscompares = 0;
    int check_count = 0;
    int n;
    alu_op_type ops [0:10] = '{AL_ADD, AL_SUB, AL_AND, AL_OR, AL_XOR, AL_CPL, AL_RR, AL_RL,
        AL_INC, AL_DEC, AL_PASS};
    logic [PW-1:0] trace [0:22] = '{10'h000, 10'h001, 10'h008, 10'h009, 10'h010, 10'h011,
        10'h009, 10'h00A, 10'h00B, 10'h00C, 10'h105, 10'h106, 10'h107, 10'h120, 10'h121,
        10'h122, 10'h130, 10'h131, 10'h140, 10'h141, 10'h150, 10'h151, 10'h160};
    // each entry packs the address above the instruction word
    logic [27:0] rom [0:29] = '{28'h000_6008, 28'h004_0200, 28'h008_7010, 28'h009_4041,
        28'h00A_3FFF, 28'h00B_6105, 28'h010_0100, 28'h105_3F20, 28'h106_5006, 28'h120_0300,
        28'h121_7130, 28'h130_7140, 28'h140_7150, 28'h150_7160, 28'h168_0100, 28'h158_0100,
        28'h141_0100, 28'h131_0100, 28'h122_6180, 28'h1A1_71B0, 28'h1B0_71B8,
        28'h1B8_71C0, 28'h1C0_71C8, 28'h1C8_71D0, 28'h1D0_5007, 28'h1D1_0100, 28'h1C9_0100,
        28'h1C1_0100, 28'h1B9_0100, 28'h1B1_0100};

    // ----------
    // clock, models and monitors
    // ----------
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    assign dmem_rdata = wr[dmem_addr];

    cpu_pmem_model #(.PC_W(PW)) u_cpu_pmem_model (.addr(pmem_addr), .data(pmem_data));

    cpu_fetch_seq #(.PC_W(PW), .STACK_DEPTH(4)) u_cpu_fetch_seq (
        .ref_clk(ref_clk), .resetn(resetn), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .tbl_ptr(tbl_ptr), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata),
        .dmem_wdata(dmem_wdata),
        .dmem_we(dmem_we), .irq_req(irq_req), .irq_ack(irq_ack), .phase(phase), .acc(acc),
        .status(status));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    initial begin
        foreach (wr[i]) wr[i] = 8'h00;
    end

    always @(negedge ref_clk) begin
        if (resetn) begin
            check(phase, (ph_q == 4'h8) ? 4'h1 : ph_q << 1);
            if (pmem_addr !== pa_q) check(phase, PH_T1);
        end
        if (dmem_we === 1'b1) begin
            check(dmem_addr == `PC_LOW_BYTE_ADDR, 1'b0);
            wr[dmem_addr] = dmem_wdata;
            ws[dmem_addr] = status;
        end
        ph_q = phase;
        pa_q = pmem_addr;
    end

    function automatic logic [8:0] alu_ref(input alu_op_type op, input logic [7:0] a,
        input logic [7:0] b);
        case (op)
            AL_ADD: return {1'b0, a} + {1'b0, b};
            AL_SUB: return {a >= b, a - b};
            AL_AND: return {1'b0, a & b};
            AL_OR: return {1'b0, a | b};
            AL_XOR: return {1'b0, a ^ b};
            AL_CPL: return {1'b0, ~b};
            AL_RR: return {1'b0, b[0], b[7:1]};
            AL_RL: return {1'b0, b[6:0], b[7]};
            AL_INC: return {1'b0, b + 8'h01};
            AL_DEC: return {1'b0, b - 8'h01};
            default: return {1'b0, b};
        endcase
    endfunction : alu_ref

    task automatic wait_addr(input logic [PW-1:0] a);
        int k;
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (!(phase === PH_T1 && pmem_addr === a) && k < 800);
    endtask : wait_addr

    task automatic next_t1();
        int k;
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (phase !== PH_T1 && k < 8);
    endtask : next_t1

    initial begin
        #(25 * 5000);
        miscompares++;
        test_done();
    end

    // ----------
    // main sequence
    // ----------
    initial begin
        void'($urandom(32'h255e5b39));
        @(negedge ref_clk);
        foreach (rom[i]) u_cpu_pmem_model.mem[rom[i][25:16]] = rom[i][14:0];
        for (int k = 0; k < 11; k++) begin
            va[k] = 8'($urandom());
            vb[k] = 8'($urandom());
            if (k == 0) {va[k], vb[k]} = 16'hFF01;
            if (k == 1) vb[k] = va[k];
            n = 'h180 + 3 * k;
            u_cpu_pmem_model.mem[n] = {3'h3, 4'hF, va[k]};
            u_cpu_pmem_model.mem[n + 1] = {3'h3, ops[k], vb[k]};
            u_cpu_pmem_model.mem[n + 2] = {3'h5, 4'h0, 8'(64 + k)};
        end
        repeat (4) @(negedge ref_clk);
        check({phase, pmem_addr, acc, status, dmem_we, irq_ack},
            {PH_T1, 10'h000, 8'h00, 4'h0, 2'b00});
        resetn <= 1'b1;
        for (int i = 1; i < 23; i++) begin
            next_t1();
            // a skip that failed to discard would have loaded FF here
            if (i == 10) check(acc, 8'h00);
            check(pmem_addr, trace[i]);
        end
        // four calls deep: the stack is now full
        wait_addr(10'h162);
        irq_req <= 1'b1;
        n = 0;
        while (!(phase === PH_T1 && pmem_addr === 10'h169) && n < 200) begin
            check(irq_ack, 1'b0);
            @(negedge ref_clk);
            n++;
        end
        n = 0;
        while (irq_ack !== 1'b1 && n < 200) begin
            if (phase === PH_T1) prv = pmem_addr;
            @(negedge ref_clk);
            n++;
        end
        check({irq_ack, pmem_addr}, {1'b1, 10'(`IRQ_VECTOR)});
        irq_req <= 1'b0;
        n = 0;
        do begin
            next_t1();
            n++;
        end while ((pmem_addr === 10'h004 || pmem_addr === 10'h005) && n < 50);
        check(pmem_addr, prv);
        wait_addr(10'h141);
        check(pmem_addr, 10'h141);
        wait_addr(10'h131);
        check(pmem_addr, 10'h131);
        wait_addr(10'h122);
        check(pmem_addr, 10'h122);
        wait_addr(10'h1A2);
        check(pmem_addr, 10'h1A2);
        for (int k = 0; k < 11; k++) begin
            logic [8:0] r;
            r = alu_ref(ops[k], va[k], vb[k]);
            check(wr[64 + k], r[7:0]);
            if (k < 2) check({ws[64 + k][`ST_C], ws[64 + k][`ST_Z]}, {r[8], r[7:0] == 0});
        end
        // a fifth call overwrites the oldest saved address
        wait_addr(10'h1B2);
        next_t1();
        check(pmem_addr, 10'h1C9);
        check(tbl_ptr, {2'b00, vb[10]});
        test_done();
    end
endmodule : cpu_fetch_pc_stack_control_bench
`default_nettype wire
